// ---- tmr_timer.sv ----
// 16-bit timer/counter with an AHB-Lite register slave.
// Assumes one clock hclk (50 MHz); the count clock and gate pins are
// asynchronous and sampled by three flip-flops.
// Contract
// - 16-bit free running counter once enabled
// - Asynchronous counter mode from external clock
// - Synchronizer placed after the prescaler stage
// - Timer modes count the instruction cycle clock
// - Counter modes count the external clock pin
// - Mode decoded from source, gate, sync bits
// - Source bit1, sync bit2, gate bit6
// - Run bit 15 starts and stops
// - Idle stop bit 13 halts in idle
// - Gate honoured only with internal clock
// - Prescale field bits 5-4 selects divide
// - Sync bit only matters with external clock
// - Source 1 counts pin rising edges
// - Count writes ignored in running sync mode
// - Unused control bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"

module tmr_timer (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire logic           hsel,
    input  wire logic [11:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic      [31:0]    hrdata,
    output logic                hreadyout,
    output logic                hresp,
    input  wire logic           external_count_clock_pin,
    input  wire logic           gate_pin,
    input  wire logic           device_idle,
    output logic                irq,
    output logic                match_pulse
);
    import tmr_pkg::*;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    logic             wr_pend;
    logic [11:0]      a_addr;
    tmr_word_t        timer_control;
    tmr_word_t        count_register;
    tmr_word_t        period;
    logic             status;
    logic             mask;
    logic             sw_idle;
    tmr_mode_t        mode;

    wire       take     = hsel & hready & htrans[1];
    wire       sel_ctl  = a_addr == `TMR_OFF_CONTROL;
    wire       sel_cnt  = a_addr == `TMR_OFF_COUNT;
    wire       sel_per  = a_addr == `TMR_OFF_PERIOD;
    wire       sel_sts  = a_addr == `TMR_OFF_STATUS;
    wire       sel_msk  = a_addr == `TMR_OFF_MASK;
    wire       sel_idl  = a_addr == `TMR_OFF_IDLE;
    wire [15:0] wdata   = hwdata[15:0];
    wire       run      = timer_control[`TMR_BIT_RUN];
    wire       clksrc   = timer_control[`TMR_BIT_CLKSRC];
    wire       syncsel  = timer_control[`TMR_BIT_SYNC];
    wire       gatesel  = timer_control[`TMR_BIT_GATE];
    wire [1:0] ps_sel   = timer_control[`TMR_BIT_PS_HI:`TMR_BIT_PS_LO];
    wire       cnt_lock = (mode == TMR_MODE_SYNC) & run;
    wire       cnt_wr   = wr_pend & sel_cnt & ~cnt_lock;
    // Read mux decodes the address phase so data stands in the data phase
    wire [15:0] rd_mux  =
        (haddr == `TMR_OFF_CONTROL) ? timer_control :
        (haddr == `TMR_OFF_COUNT)   ? count_register :
        (haddr == `TMR_OFF_PERIOD)  ? period :
        (haddr == `TMR_OFF_STATUS)  ? {15'h0000, status} :
        (haddr == `TMR_OFF_MASK)    ? {15'h0000, mask} :
        (haddr == `TMR_OFF_IDLE)    ? {15'h0000, sw_idle} : 16'h0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            a_addr  <= 12'h000;
        end else begin
            wr_pend <= take & hwrite;
            a_addr  <= take ? haddr : a_addr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= (take & ~hwrite) ? {16'h0000, rd_mux} :
                                            32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control and configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_control <= `TMR_CONTROL_RST;
            period        <= `TMR_PERIOD_RST;
            mask          <= 1'b0;
            sw_idle       <= 1'b0;
        end else if (wr_pend) begin
            if (sel_ctl) timer_control <= wdata & `TMR_CONTROL_MASK;
            if (sel_per) period <= wdata;
            if (sel_msk) mask <= wdata[0];
            if (sel_idl) sw_idle <= wdata[0];
        end
    end

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // mode from source, gate, sync
    assign mode = clksrc ? (syncsel ? TMR_MODE_SYNC : TMR_MODE_ASYNC)
                         : (gatesel ? TMR_MODE_GATED : TMR_MODE_TIMER);

    // ------------------------------------------------------------------
    // Pin sampling; only stages two and three are looked at
    // ------------------------------------------------------------------
    logic [2:0] gt_s;
    logic       gate_lvl;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gt_s     <= 3'h0;
            gate_lvl <= 1'b0;
        end else begin
            gt_s     <= {gt_s[1:0], gate_pin};
            gate_lvl <= (gt_s[2] == gt_s[1]) ? gt_s[1] : gate_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Prescaler on the raw pin: divides pin edges before any sync
    // ------------------------------------------------------------------
    // prescaler sits before the synchroniser
    logic [7:0] pin_ps;
    logic       pin_ps_out;
    logic [7:0] ps_term;
    assign ps_term = (ps_sel == 2'h3) ? `TMR_PS_DIV256 :
                     (ps_sel == 2'h2) ? `TMR_PS_DIV64 :
                     (ps_sel == 2'h1) ? `TMR_PS_DIV8 : `TMR_PS_DIV1;
    always_ff @(posedge external_count_clock_pin or negedge hresetn) begin
        if (!hresetn) begin
            pin_ps     <= 8'h00;
            pin_ps_out <= 1'b0;
        end else if (pin_ps >= ps_term) begin
            pin_ps     <= 8'h00;
            pin_ps_out <= ~pin_ps_out;
        end else begin
            pin_ps     <= pin_ps + 8'h01;
        end
    end

    // Prescaled pin toggle brought to hclk by three flip-flops
    logic [2:0] pt_s;
    logic       pt_seen;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pt_s    <= 3'h0;
            pt_seen <= 1'b0;
        end else begin
            pt_s    <= {pt_s[1:0], pin_ps_out};
            pt_seen <= (pt_s[2] == pt_s[1]) ? pt_s[1] : pt_seen;
        end
    end
    wire pin_tick = (pt_s[2] == pt_s[1]) & (pt_s[1] != pt_seen);

    // ------------------------------------------------------------------
    // Internal clock prescaler
    // ------------------------------------------------------------------
    // timer modes use the instruction clock
    logic [7:0] int_ps;
    wire halted   = ~run | (timer_control[`TMR_BIT_IDLESTOP] &
                            (device_idle | sw_idle));
    // gated mode advances only with gate high
    wire int_en   = ~clksrc & ~halted &
                    ((mode != TMR_MODE_GATED) | gate_lvl);
    wire int_tick = int_en & (int_ps >= ps_term);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) int_ps <= 8'h00;
        else if (!int_en || int_tick) int_ps <= 8'h00;
        else int_ps <= int_ps + 8'h01;
    end

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // counter modes use the pin
    // async mode takes pin ticks without waiting on the gate path
    // idle stop halts counting
    // Limitation: the asynchronous mode still reads its count through
    // the hclk domain, so counting rate is bounded by hclk.
    wire ext_tick = clksrc & ~halted & pin_tick;
    wire tick     = int_tick | ext_tick;
    wire match    = tick & (count_register == period);
    tmr_word_t next_count;
    assign next_count = match ? `TMR_COUNT_RST :
                        tick  ? count_register + 16'h0001 : count_register;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_register <= `TMR_COUNT_RST;
            match_pulse    <= 1'b0;
        end else begin
            count_register <= cnt_wr ? wdata : next_count;
            match_pulse    <= match;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt: status set wins over write-one clear
    // ------------------------------------------------------------------
    wire sts_clr = wr_pend & sel_sts & hwdata[0];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= 1'b0;
            irq    <= 1'b0;
        end else begin
            status <= match | (status & ~sts_clr);
            irq    <= (match | (status & ~sts_clr)) & mask;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    cnt_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend & sel_cnt & cnt_lock & ~tick) |=>
            $stable(count_register))
        else $error("count changed by write in sync mode");
    ctl_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (timer_control & ~`TMR_CONTROL_MASK) == 16'h0000)
        else $error("unused control bit set");
    run_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (~run & ~cnt_wr) |=> $stable(count_register))
        else $error("count moved while stopped");
    idle_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (timer_control[`TMR_BIT_IDLESTOP] & device_idle & ~cnt_wr)
            |=> $stable(count_register))
        else $error("count moved in idle stop");
    gate_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode == TMR_MODE_GATED & ~gate_lvl) |-> ~tick)
        else $error("gated mode counted with gate low");
    match_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (match & ~cnt_wr) |=> (count_register == 16'h0000) && status)
        else $error("match did not clear count or set flag");
    int_src_a: assert property (@(posedge hclk) disable iff (!hresetn)
        clksrc |-> ~int_tick)
        else $error("internal tick with external source");
    ext_src_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ~clksrc |-> ~ext_tick)
        else $error("pin tick with internal source");
    div1_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (int_en & ps_sel == 2'h0) |-> int_tick)
        else $error("divide by one did not tick each cycle");
    irq_lvl_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (status & mask & ~sts_clr) |=> irq)
        else $error("interrupt not raised");

endmodule // tmr_timer

`default_nettype wire

// ---- tmr_params.svh ----
// Constants of the 16-bit timer/counter: offsets, fields, reset values.
// Assumes inclusion by bare name from the bench and the design file.
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TMR_OFF_CONTROL   12'h000
`define TMR_OFF_COUNT     12'h004
`define TMR_OFF_PERIOD    12'h008
`define TMR_OFF_STATUS    12'h00c
`define TMR_OFF_MASK      12'h010
`define TMR_OFF_IDLE      12'h014

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define TMR_BIT_RUN       15
`define TMR_BIT_IDLESTOP  13
`define TMR_BIT_GATE      6
`define TMR_BIT_PS_HI     5
`define TMR_BIT_PS_LO     4
`define TMR_BIT_SYNC      2
`define TMR_BIT_CLKSRC    1
`define TMR_CONTROL_MASK  16'ha076
`define TMR_CONTROL_RST   16'h0000
`define TMR_COUNT_RST     16'h0000
`define TMR_PERIOD_RST    16'hffff

// ----------------------------------------------------------------------
// Prescaler terminal counts (divide minus one)
// ----------------------------------------------------------------------
`define TMR_PS_DIV1       8'h00
`define TMR_PS_DIV8       8'h07
`define TMR_PS_DIV64      8'h3f
`define TMR_PS_DIV256     8'hff

`endif

// ---- tmr_pkg.sv ----
// Types shared by the timer/counter.
// Assumes tmr_params.svh is on the include path.
package tmr_pkg;
    typedef enum logic [1:0] {
        TMR_MODE_TIMER = 2'h0,
        TMR_MODE_GATED = 2'h1,
        TMR_MODE_SYNC  = 2'h2,
        TMR_MODE_ASYNC = 2'h3
    } tmr_mode_t;
    typedef logic [15:0] tmr_word_t;
endpackage

// ---- tmr_pin_src.sv ----
// Far-side model: external count clock pin and gate pin of the timer.
// Assumes tb hclk; edges are slow (8 hclk per period) as the pins need.
`timescale 1ns/1ps
`default_nettype none

module tmr_pin_src (
    input  wire logic hclk,
    output var  logic pin,
    output var  logic gate
);
    initial begin
        pin  = 1'b0;
        gate = 1'b0;
    end
    // ------------------------------------------------------------
    // Pin stimulus
    // ------------------------------------------------------------
    // rising edges
    // Clock stands low between bursts, never runs free
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge hclk);
            pin <= 1'b1;
            repeat (4) @(posedge hclk);
            pin <= 1'b0;
        end
        repeat (8) @(posedge hclk);
    endtask
    task automatic set_gate(input logic g);
        @(posedge hclk);
        gate <= g;
    endtask
endmodule // tmr_pin_src

`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for tmr_timer over AHB-Lite.
// Assumes tmr_params.svh and tmr_pin_src; period kept at 3 to stay short.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end

module tb;
    import tmr_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        idle = 1'b0;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         irq;
    wire         match_pulse;
    wire         pin;
    wire         gate;
    int          err_total = 0;
    int          n_tests = 0;
    int          m_cnt = 0;
    int          c;
    logic [31:0] q;

    always #10 hclk = ~hclk;
    always @(posedge hclk) if (match_pulse === 1'b1) m_cnt++;

    tmr_timer tmr_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .external_count_clock_pin(pin),
        .gate_pin(gate), .device_idle(idle), .irq(irq),
        .match_pulse(match_pulse));
    tmr_pin_src tmr_pin_src_inst (.hclk(hclk), .pin(pin), .gate(gate));

    // ------------------------------------------------------------
    // Bus and timing helpers
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    // Cycles until the next match, capped at lim
    task automatic wait_m(input int lim, output int n);
        n = 0;
        do begin @(posedge hclk); n++; end
        while (match_pulse !== 1'b1 && n < lim);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        bus(1'b0, `TMR_OFF_CONTROL, 32'h0, q);
        `CHK("ctl_rst", 32'h0, q)
        `CHK("hresp", 1'b0, hresp)
        bus(1'b0, `TMR_OFF_PERIOD, 32'h0, q);
        `CHK("per_rst", 32'h0000ffff, q)
        wr(`TMR_OFF_CONTROL, 32'hffffffff);
        bus(1'b0, `TMR_OFF_CONTROL, 32'h0, q);
        `CHK("ctl_mask", 32'h0000a076, q)
        wr(12'h100, 32'h1234);
        bus(1'b0, 12'h100, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        wr(`TMR_OFF_CONTROL, 32'h0);
        wr(`TMR_OFF_PERIOD, 32'h3);
        $display("test regs done");
    endtask
    task automatic t_prescale();
        int div [4] = '{1, 8, 64, 256};
        for (int k = 0; k < 4; k++) begin
            wr(`TMR_OFF_CONTROL, 32'h8000 | (k << 4));
            wait_m(3000, c);
            wait_m(3000, c);
            `CHK("ps_gap", 4 * div[k], c)
        end
        wr(`TMR_OFF_CONTROL, 32'h0);
        wait_m(1200, c);
        `CHK("stopped", 1200, c)
        $display("test prescale done");
    endtask
    task automatic t_gate_idle();
        wr(`TMR_OFF_CONTROL, 32'h8040);
        wait_m(200, c);
        `CHK("gate_low", 200, c)
        tmr_pin_src_inst.set_gate(1'b1);
        wait_m(200, c);
        wait_m(200, c);
        `CHK("gate_high", 4, c)
        tmr_pin_src_inst.set_gate(1'b0);
        idle <= 1'b1;
        wr(`TMR_OFF_CONTROL, 32'ha000);
        wait_m(200, c);
        `CHK("idle_stop", 200, c)
        wr(`TMR_OFF_CONTROL, 32'h8000);
        wait_m(200, c);
        wait_m(200, c);
        `CHK("idle_run", 4, c)
        idle <= 1'b0;
        $display("test gate idle done");
    endtask
    task automatic t_ext();
        for (int s = 1; s >= 0; s--) begin
            wr(`TMR_OFF_CONTROL, 32'h0);
            wr(`TMR_OFF_COUNT, 32'h0);
            wr(`TMR_OFF_CONTROL, 32'h8042 | (s << 2));
            c = m_cnt;
            tmr_pin_src_inst.pulses(8);
            `CHK("ext_matches", 2, m_cnt - c)
        end
        wr(`TMR_OFF_CONTROL, 32'h8006);
        wr(`TMR_OFF_COUNT, 32'h3);
        c = m_cnt;
        tmr_pin_src_inst.pulses(1);
        `CHK("cnt_wr_ign", 0, m_cnt - c)
        bus(1'b0, `TMR_OFF_COUNT, 32'h0, q);
        `CHK("cnt_val", 32'h1, q)
        $display("test ext done");
    endtask
    task automatic t_irq();
        wr(`TMR_OFF_CONTROL, 32'h8000);
        wait_m(200, c);
        wr(`TMR_OFF_CONTROL, 32'h0);
        repeat (3) @(posedge hclk);
        `CHK("irq_masked", 1'b0, irq)
        bus(1'b0, `TMR_OFF_STATUS, 32'h0, q);
        `CHK("status", 32'h1, q)
        wr(`TMR_OFF_MASK, 32'h1);
        repeat (3) @(posedge hclk);
        `CHK("irq_on", 1'b1, irq)
        wr(`TMR_OFF_STATUS, 32'h1);
        repeat (3) @(posedge hclk);
        `CHK("irq_clr", 1'b0, irq)
        $display("test irq done");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_prescale();
        t_gate_idle();
        t_ext();
        t_irq();
        wrap_up();
    end
    // Whole run needs about 5k cycles
    initial begin
        #(20 * 60000);
        err_total++;
        wrap_up();
    end
endmodule // tb

`default_nettype wire
